// >>> design/sal_host.sv
// Purpose: host end: loads attenuation words over the three-wire link
// Assumes: plain register port, read data one cycle after read strobe
// Notes: serial clock derived from mclk; 2 mclk per phase gives 5 MHz
`timescale 1ns/100ps
module sal_host
  import sal_pkg::*;
#(
  parameter int unsigned HALF_CYC = SAL_HALF_CYC
) (
  input wire logic mclk, // clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic [3:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  sal_if.host link // serial link to device
);
  if (HALF_CYC < SAL_HALF_CYC_MIN || HALF_CYC < SAL_PHASE_CYC
      || HALF_CYC > 255) begin : g_bad_half
    $error("sal_host: HALF_CYC out of range");
  end
  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
  localparam logic [7:0] PW_M1 =
    8'(SAL_STB_PW_CYC > HALF_CYC ? SAL_STB_PW_CYC - 1 : HALF_CYC - 1);
  localparam logic [7:0] SU_M1 =
    8'(SAL_STB_SU_CYC > HALF_CYC ? SAL_STB_SU_CYC - 1 : HALF_CYC - 1);

  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_SETUP, ST_LATCH} sal_hst_e_t;
  typedef struct packed {
    sal_hst_e_t fsm;
    logic [7:0] tmr;
    logic [2:0] bitn;
    logic [7:0] word;
    logic [7:0] sent;
    logic pd;
    logic sdat;
    logic sclk;
    logic stb;
    logic [31:0] rdata;
  } sal_hst_st_t;
  sal_hst_st_t st_q, st_d;

  //------------------------------------------------------------
  // register port and serial sequencer
  //------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rdata = 32'h0000_0000;
    if (st_q.tmr != 8'h00) begin
      st_d.tmr = st_q.tmr - 8'h01;
    end
    if (reg_rd) begin
      if (reg_addr == SAL_REG_CTRL) begin
        st_d.rdata = {30'h0, st_q.pd, 1'b0};
      end else if (reg_addr == SAL_REG_WORD) begin
        st_d.rdata = {24'h00_0000, st_q.word};
      end else if (reg_addr == SAL_REG_STAT) begin
        st_d.rdata = {30'h0, st_q.pd, st_q.fsm != ST_IDLE};
      end else if (reg_addr == SAL_REG_APPLIED) begin
        st_d.rdata = {24'h00_0000, st_q.sent};
      end
    end
    if (reg_wr) begin
      if (reg_addr == SAL_REG_WORD) begin
        st_d.word = {1'b0, reg_wdata[6:0]};
      end else if (reg_addr == SAL_REG_CTRL) begin
        st_d.pd = reg_wdata[SAL_CTRL_PD];
      end
    end
    case (st_q.fsm)
      ST_IDLE: begin
        if (reg_wr && reg_addr == SAL_REG_CTRL && reg_wdata[SAL_CTRL_GO]) begin
          st_d.fsm = ST_LOW;
          st_d.bitn = 3'h0;
          st_d.stb = 1'b0;
          st_d.sdat = st_q.word[0];
          st_d.tmr = HALF_M1;
        end
      end
      ST_LOW: begin
        if (st_q.tmr == 8'h00) begin
          st_d.sclk = 1'b1;
          st_d.fsm = ST_HIGH;
          st_d.tmr = HALF_M1;
        end
      end
      ST_HIGH: begin
        if (st_q.tmr == 8'h00) begin
          st_d.sclk = 1'b0;
          if (st_q.bitn == 3'h7) begin
            st_d.fsm = ST_SETUP;
            st_d.tmr = SU_M1;
          end else begin
            st_d.bitn = st_q.bitn + 3'h1;
            st_d.sdat = st_q.word[st_q.bitn + 3'h1];
            st_d.fsm = ST_LOW;
            st_d.tmr = HALF_M1;
          end
        end
      end
      ST_SETUP: begin
        if (st_q.tmr == 8'h00) begin
          st_d.stb = 1'b1;
          st_d.fsm = ST_LATCH;
          st_d.tmr = PW_M1;
        end
      end
      ST_LATCH: begin
        if (st_q.tmr == 8'h00) begin
          st_d.stb = 1'b0;
          st_d.sent = st_q.word;
          st_d.fsm = ST_IDLE;
        end
      end
      default: st_d.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q.fsm <= ST_IDLE;
      st_q.tmr <= 8'h00;
      st_q.bitn <= 3'h0;
      st_q.word <= SAL_WORD_MAX;
      st_q.sent <= SAL_WORD_RST;
      st_q.pd <= 1'b0;
      st_q.sdat <= 1'b0;
      st_q.sclk <= 1'b0;
      st_q.stb <= 1'b0;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign link.ser_data = st_q.sdat;
  assign link.ser_clk = st_q.sclk;
  assign link.latch_load_strobe = st_q.stb;
  assign link.pwr_down = st_q.pd;
endmodule // sal_host

// >>> design/sal_pkg.sv
// Purpose: shared constants for the serial attenuator word loader
// Assumes: mclk at 20 MHz, link clock sampled as a plain input
// Notes: all counts in mclk cycles derived from printed times
package sal_pkg;
  localparam int unsigned SAL_MCLK_HZ = 20_000_000;
  localparam int unsigned SAL_MCLK_NS = 1_000_000_000 / SAL_MCLK_HZ;
  localparam int unsigned SAL_WORD_W = 8;
  // least clock phase and latch pulse width, rounded up
  localparam int unsigned SAL_PHASE_MIN_NS = 30;
  localparam int unsigned SAL_STB_PW_MIN_NS = 30;
  localparam int unsigned SAL_STB_SU_MIN_NS = 10;
  localparam int unsigned SAL_PHASE_CYC = (SAL_PHASE_MIN_NS + SAL_MCLK_NS - 1) / SAL_MCLK_NS;
  localparam int unsigned SAL_STB_PW_CYC = (SAL_STB_PW_MIN_NS + SAL_MCLK_NS - 1) / SAL_MCLK_NS;
  localparam int unsigned SAL_STB_SU_CYC = (SAL_STB_SU_MIN_NS + SAL_MCLK_NS - 1) / SAL_MCLK_NS;
  // host clock divider: half period in mclk cycles, 10 MHz max
  localparam int unsigned SAL_SCLK_MAX_HZ = 10_000_000;
  localparam int unsigned SAL_HALF_CYC_MIN = SAL_MCLK_HZ / (2 * SAL_SCLK_MAX_HZ);
  localparam int unsigned SAL_HALF_CYC = 2;
  // power-up word: 31.75 dB, top bit zero
  localparam logic [7:0] SAL_WORD_RST = 8'h7F;
  localparam logic [7:0] SAL_WORD_MAX = 8'h7F;
  // host register map (word-indexed byte addresses)
  localparam logic [3:0] SAL_REG_CTRL = 4'h0;
  localparam logic [3:0] SAL_REG_WORD = 4'h4;
  localparam logic [3:0] SAL_REG_STAT = 4'h8;
  localparam logic [3:0] SAL_REG_APPLIED = 4'hC;
  localparam int unsigned SAL_CTRL_GO = 0;
  localparam int unsigned SAL_CTRL_PD = 1;
  localparam int unsigned SAL_STAT_BUSY = 0;
  localparam int unsigned SAL_STAT_PD = 1;
endpackage

// >>> design/sal_if.sv
// Purpose: three-wire serial link plus power-down between host and device
// Assumes: all signals single-driven by the host
// Notes: no clocking block; the bench joins both ends
`timescale 1ns/100ps
interface sal_if;
  logic ser_data; // serial data, lsb first
  logic ser_clk; // serial clock, made by host
  logic latch_load_strobe; // high makes latch transparent
  logic pwr_down; // high disables amplifiers
  modport host (output ser_data, output ser_clk, output latch_load_strobe, output pwr_down);
  modport dev (input ser_data, input ser_clk, input latch_load_strobe, input pwr_down);
endinterface

// >>> design/sal_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: destination clock mclk
// Notes: first stage is read by the second stage only
`timescale 1ns/100ps
module sal_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic mclk, // clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic [WIDTH-1:0] async_in, // pins
  output logic [WIDTH-1:0] sync_out // synchronised level
);
  if (WIDTH < 1) begin : g_bad_width
    $error("sal_sync: WIDTH must be at least 1");
  end
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sal_sync_st_t;
  sal_sync_st_t st_q, st_d;

  always_comb begin
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync;
endmodule // sal_sync

// >>> design/sal_dev.sv
// Purpose: device end: shift register, latch and power-down of a stepped attenuator
// Assumes: link pins sampled on mclk; serial clock at most mclk/4
// Notes: word bit i weighs 0.25 dB * 2**i; shift register resets like the latch
`timescale 1ns/100ps
module sal_dev
  import sal_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic sys_rst, // sync reset, active high
  sal_if.dev link, // serial link from host
  output logic [7:0] step_attenuator, // applied attenuation word
  output logic amp_enable, // amplifiers on
  output logic [7:0] shift_word // shift register contents
);
  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  logic [3:0] pins_s;
  sal_sync #(.WIDTH(4)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({link.pwr_down, link.latch_load_strobe, link.ser_clk, link.ser_data}),
    .sync_out(pins_s)
  );

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  typedef struct packed {
    logic clk_prev;
    logic [7:0] sr; // only serial load path exists
    logic [7:0] latch;
    logic amp_en;
  } sal_dev_st_t;
  sal_dev_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.clk_prev = pins_s[1];
    // new bit enters the top, so after eight shifts the first bit sits at bit zero
    if (pins_s[1] && !st_q.clk_prev) begin
      st_d.sr = {pins_s[0], st_q.sr[7:1]};
    end
    // transparent latch: follows the register, including a shift in the same cycle
    if (pins_s[2]) begin
      st_d.latch = st_d.sr;
    end
    st_d.amp_en = !pins_s[3];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q.clk_prev <= 1'b0;
      st_q.sr <= SAL_WORD_RST;
      st_q.latch <= SAL_WORD_RST;
      st_q.amp_en <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // attenuation is sum of bit weights, bit0 = quarter dB
  assign step_attenuator = st_q.latch;
  assign amp_enable = st_q.amp_en;
  assign shift_word = st_q.sr;
endmodule // sal_dev

// >>> tb/sal_assertions.sv
// Purpose: checks on the link and the device outputs
// Assumes: host half period 2 mclk, device pin latency 3-4 mclk
// Notes: instanced beside the link interface, no bind
`timescale 1ns/100ps
module sal_assertions (
  input wire logic mclk, // clock
  input wire logic sys_rst, // sync reset
  input wire logic ser_data, // serial data
  input wire logic ser_clk, // serial clock
  input wire logic latch_load_strobe, // latch strobe
  input wire logic pwr_down, // power-down
  input wire logic [7:0] step_attenuator, // applied word
  input wire logic amp_enable, // amps on
  input wire logic [7:0] shift_word // shift register
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_rise; $rose(ser_clk); endsequence
  sequence s_stb; $rose(latch_load_strobe); endsequence
  sequence s_pd; $rose(pwr_down) ##0 (!ser_clk && !latch_load_strobe)[*6]; endsequence
  property p_phase; s_rise |-> ser_clk[*2]; endproperty
  a_phase: assert property (p_phase) else $error("clock phase short");
  property p_stb_low; s_rise |-> !latch_load_strobe; endproperty
  a_stb_low: assert property (p_stb_low) else $error("strobe high in shift");
  property p_stb_setup; s_stb |-> !ser_clk ##1 latch_load_strobe; endproperty
  a_stb_setup: assert property (p_stb_setup) else $error("strobe timing");
  property p_stb_pulse; s_stb |-> ##[1:8] !latch_load_strobe; endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe stuck");
  // data is held two mclk past the rise, so five cycles on it sits in bit 7
  property p_shift; s_rise |-> ##5 shift_word[7] == $past(ser_data, 5); endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted");
  property p_hold; !latch_load_strobe[*5] |-> $stable(step_attenuator); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_follow; s_stb |-> ##5 step_attenuator == shift_word; endproperty
  a_follow: assert property (p_follow) else $error("latch missed");
  property p_top; s_stb |-> ##5 !step_attenuator[7]; endproperty
  a_top: assert property (p_top) else $error("top bit set");
  property p_pd_off; pwr_down[*5] |-> !amp_enable; endproperty
  a_pd_off: assert property (p_pd_off) else $error("amps left on");
  property p_pd_on; !pwr_down[*5] |-> amp_enable; endproperty
  a_pd_on: assert property (p_pd_on) else $error("amps left off");
  property p_pd_keep;
    s_pd |-> shift_word == $past(shift_word, 5) && step_attenuator == $past(step_attenuator, 5);
  endproperty
  a_pd_keep: assert property (p_pd_keep) else $error("power-down moved word");
endmodule // sal_assertions

// >>> tb/serial_attenuator_word_loader_tb.sv
// Purpose: host and device joined over the link, loads checked end to end
// Assumes: default host half period
// Notes: the host divides mclk for the link clock, the bench makes none
`timescale 1ns/100ps
module serial_attenuator_word_loader_tb
  import sal_pkg::*;
;
  // -----
  // setup
  // -----
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] step_attenuator;
  logic amp_enable;
  logic [7:0] shift_word;
  int num_errors = 0;
  int samples_checked = 0;
  always #25 mclk = ~mclk;
  sal_if sal_if_i ();
  sal_host sal_host_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(sal_if_i.host));
  sal_dev sal_dev_i (.mclk(mclk), .sys_rst(sys_rst), .link(sal_if_i.dev),
    .step_attenuator(step_attenuator), .amp_enable(amp_enable), .shift_word(shift_word));
  sal_assertions sal_assertions_i (.mclk(mclk), .sys_rst(sys_rst),
    .ser_data(sal_if_i.ser_data), .ser_clk(sal_if_i.ser_clk),
    .latch_load_strobe(sal_if_i.latch_load_strobe), .pwr_down(sal_if_i.pwr_down),
    .step_attenuator(step_attenuator), .amp_enable(amp_enable), .shift_word(shift_word));
  // -----
  // tests
  // -----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic load(input logic [7:0] w, input logic [7:0] old);
    logic [31:0] s;
    wr(SAL_REG_WORD, {24'h0000_00, w});
    wr(SAL_REG_CTRL, 32'h0000_0001);
    repeat (12) @(negedge mclk);
    chk(step_attenuator, old);
    s = 32'h0000_0001;
    for (int i = 0; i < 100 && s[SAL_STAT_BUSY] === 1'b1; i++) rd(SAL_REG_STAT, s);
    chk(s[SAL_STAT_BUSY], 1'b0);
    repeat (8) @(negedge mclk);
    chk(step_attenuator, w & 8'h7F);
    chk(shift_word, w & 8'h7F);
    rd(SAL_REG_APPLIED, s);
    chk(s, w & 8'h7F);
    rd(SAL_REG_WORD, s);
    chk(s, w & 8'h7F);
  endtask
  task automatic t_reset();
    logic [31:0] s;
    repeat (6) @(negedge mclk);
    chk(step_attenuator, SAL_WORD_RST);
    chk(amp_enable, 1'b1);
    rd(4'h2, s);
    chk(s, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_words();
    logic [7:0] prev;
    load(8'h32, 8'h7F);
    prev = 8'h32;
    for (int i = 0; i < 7; i++) begin
      load(8'(8'h01 << i), prev);
      prev = 8'(8'h01 << i);
    end
    load(8'hFF, prev);
    load(8'h00, 8'h7F);
    $display("word test done");
  endtask
  task automatic t_pd();
    logic [31:0] s;
    // a non-zero word first, so a power-down that clears the word is caught
    load(8'h2A, 8'h00);
    wr(SAL_REG_CTRL, 32'h0000_0002);
    repeat (8) @(negedge mclk);
    chk(amp_enable, 1'b0);
    chk({shift_word, step_attenuator}, 16'h2A2A);
    rd(SAL_REG_STAT, s);
    chk(s, 32'h0000_0002);
    rd(SAL_REG_CTRL, s);
    chk(s, 32'h0000_0002);
    wr(SAL_REG_CTRL, 32'h0000_0000);
    repeat (8) @(negedge mclk);
    chk(amp_enable, 1'b1);
    chk({shift_word, step_attenuator}, 16'h2A2A);
    $display("power-down test done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_words();
    t_pd();
    stop_test();
  end
  // a frame takes well under 100 mclk, so this span only trips on a hang
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    stop_test();
  end
endmodule // serial_attenuator_word_loader_tb
